//--- logic/aovp_pkg.sv
// Package for the analog output value and parameter port
package aovp_pkg;
  localparam int unsigned NumChan = 4;
  localparam int unsigned ParamBytes = 16;
  localparam int unsigned Rec0Bytes = 2;
  localparam int unsigned Rec1Bytes = 14;
  localparam int unsigned SignPos = 15;
  localparam logic [3:0] DiagOffset = 4'h0;
  localparam logic [3:0] SpareOffset = 4'h1;
  localparam logic [7:0] DiagReset = 8'h00;
  localparam logic [7:0] DiagMask = 8'h0f;
  localparam logic [3:0] Rec1ModeBase = 4'h2;
  localparam logic [7:0] Rec1Byte0Mask = 8'h40;
  localparam logic [7:0] Rec1Byte1Mask = 8'h0f;
  localparam logic [3:0] TypeOff = 4'h0;
  localparam logic [3:0] TypeVolt = 4'h1;
  localparam logic [3:0] TypeCurr = 4'h2;
  localparam logic [7:0] ModeDefault = 8'h19;
  localparam logic [15:0] WordReset = 16'h0000;

  typedef enum logic [1:0] {AOVP_RES12, AOVP_RES11, AOVP_RES10} aovp_res_t;

  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    logic [7:0] hiByte;
    logic [7:0] loByte;
  } aovp_word_t;

  typedef struct packed {
    logic valid;
    logic recSet;
    logic [3:0] index;
    logic [7:0] data;
  } aovp_prm_t;
endpackage : aovp_pkg

//--- logic/aovp_port.sv
// Analog output value and parameter port
`timescale 1ns/10ps
`default_nettype none
module aovp_port #(
  parameter aovp_pkg::aovp_res_t Resolution = aovp_pkg::AOVP_RES12,
  parameter logic [3:0] SupportedTypes = 4'h7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Output value words from the controller
  input wire aovp_pkg::aovp_word_t valueIn,
  // Parameter record bytes from the controller
  input wire aovp_pkg::aovp_prm_t prmIn,
  input wire logic runStart,
  // Diagnosis events per channel and record set 0 and 1 read
  input wire logic [3:0] chanFault,
  input wire logic [3:0] diagRdIndex,
  output logic [7:0] diagRdData,
  // Results
  output logic [15:0] dacCode0,
  output logic [15:0] dacCode1,
  output logic [15:0] dacCode2,
  output logic [15:0] dacCode3,
  output logic [31:0] chanMode,
  output logic prmError,
  output logic prmRefused,
  output logic prmApplied
);
  import aovp_pkg::*;

  // ****************************************
  // Resolution masking
  // ****************************************
  function automatic logic [15:0] keepMask(input aovp_res_t r);
    case (r)
      AOVP_RES11: keepMask = 16'hfff0;
      AOVP_RES10: keepMask = 16'hffe0;
      default: keepMask = 16'hfff8;
    endcase
  endfunction : keepMask

  function automatic logic modeOk(input logic [7:0] m);
    modeOk = 1'b0;
    if (m[7:4] == TypeOff) begin
      modeOk = 1'b1;
    end else if (m[7:4] == TypeVolt || m[7:4] == TypeCurr) begin
      modeOk = SupportedTypes[m[5:4]];
    end
  endfunction : modeOk

  function automatic logic isModeIndex(input logic [3:0] idx);
    isModeIndex = (idx >= Rec1ModeBase) && (idx < Rec1ModeBase + 4'(NumChan));
  endfunction : isModeIndex

  function automatic logic [7:0] keepBits(input logic [3:0] idx);
    if (idx == 4'h0) begin
      keepBits = Rec1Byte0Mask;
    end else if (idx == 4'h1) begin
      keepBits = Rec1Byte1Mask;
    end else begin
      keepBits = 8'hff;
    end
  endfunction : keepBits

  // ****************************************
  // Channel value registers
  // ****************************************
  logic [15:0] code [NumChan];
  logic [15:0] word;

  assign word = {valueIn.hiByte, valueIn.loByte};

  // One register per channel, loaded only by its own strobe
  for (genvar g = 0; g < NumChan; g++) begin : g_chan
    logic [15:0] next_code;

    always_comb begin
      next_code = code[g];
      if (valueIn.valid && valueIn.chan == 2'(g)) begin
        next_code = word & keepMask(Resolution);
      end
    end

    always_ff @(posedge clk) begin
      if (!nrst) begin
        code[g] <= WordReset;
      end else begin
        code[g] <= next_code;
      end
    end
  end : g_chan

  // ****************************************
  // Summary diagnosis
  // ****************************************
  logic [7:0] diag;
  logic [7:0] next_diag;

  always_comb begin
    next_diag = (diag | {4'h0, chanFault}) & DiagMask;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      diag <= DiagReset;
    end else begin
      diag <= next_diag;
    end
  end

  // ****************************************
  // Parameter record decode
  // ****************************************
  logic prmBlocked;
  logic prmInvalid;
  logic prmAccept;

  always_comb begin
    // One verdict per strobe: refused, invalid or accepted
    prmBlocked = 1'b0;
    prmInvalid = 1'b0;
    prmAccept = 1'b0;
    if (prmIn.valid) begin
      if (prmIn.recSet == 1'b0 || prmIn.index >= 4'(Rec1Bytes)) begin
        prmBlocked = 1'b1;
      end else if (isModeIndex(prmIn.index) && !modeOk(prmIn.data)) begin
        prmInvalid = 1'b1;
      end else begin
        prmAccept = 1'b1;
      end
    end
  end

  // ****************************************
  // Record set 1 storage
  // ****************************************
  logic [7:0] rec1 [Rec1Bytes];
  logic [7:0] next_rec1 [Rec1Bytes];

  always_comb begin
    for (int i = 0; i < Rec1Bytes; i++) begin
      next_rec1[i] = rec1[i];
    end
    if (prmAccept) begin
      next_rec1[prmIn.index] = prmIn.data & keepBits(prmIn.index);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      // Mode bytes start at their default code
      for (int i = 0; i < Rec1Bytes; i++) begin
        rec1[i] <= isModeIndex(4'(i)) ? ModeDefault : 8'h00;
      end
    end else begin
      rec1 <= next_rec1;
    end
  end

  // ****************************************
  // Status pulses and run arm
  // ****************************************
  logic next_prmError;
  logic next_prmRefused;
  logic next_prmApplied;
  logic armed;
  logic next_armed;

  always_comb begin
    next_prmError = prmInvalid;
    next_prmRefused = prmBlocked;
    next_prmApplied = prmAccept;
    // Run start arms; an accepted record clears it
    next_armed = (armed | runStart) & ~prmAccept;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prmError <= 1'b0;
      prmRefused <= 1'b0;
      prmApplied <= 1'b0;
      armed <= 1'b0;
    end else begin
      prmError <= next_prmError;
      prmRefused <= next_prmRefused;
      prmApplied <= next_prmApplied;
      armed <= next_armed;
    end
  end

  // ****************************************
  // Read back and outputs
  // ****************************************
  always_comb begin
    if (diagRdIndex == DiagOffset) begin
      diagRdData = diag;
    end else if (diagRdIndex == SpareOffset) begin
      diagRdData = 8'h00;
    end else begin
      diagRdData = rec1[diagRdIndex - 4'(Rec0Bytes)];
    end
  end

  assign dacCode0 = code[0];
  assign dacCode1 = code[1];
  assign dacCode2 = code[2];
  assign dacCode3 = code[3];
  assign chanMode = {rec1[5], rec1[4], rec1[3], rec1[2]};
endmodule : aovp_port
`default_nettype wire

//--- sim/aovp_ctrl.sv
// Controller model
`timescale 1ns/10ps
`default_nettype none
module aovp_ctrl import aovp_pkg::*; (
  // Clock
  input wire logic clk,
  // Strobes to the port
  output var aovp_word_t valueIn = '0,
  output var aovp_prm_t prmIn = '0
);
  task automatic word(input logic [1:0] c, input logic [15:0] w);
    @(posedge clk) #1 valueIn = {1'b1, c, w};
    @(posedge clk) #1 valueIn = {1'b0, ~c, ~w};
  endtask : word
  task automatic prm(input logic r, input logic [3:0] i, input logic [7:0] d);
    @(posedge clk) #1 prmIn = {1'b1, r, i, d};
    @(posedge clk) #1 prmIn = {1'b0, ~r, ~i, ~d};
  endtask : prm
endmodule : aovp_ctrl
`default_nettype wire

//--- sim/aovp_port_properties.sv
// Checker for the analog output value and parameter port
`timescale 1ns/10ps
`default_nettype none
module aovp_port_properties import aovp_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Controller strobes
  input wire aovp_word_t valueIn,
  input wire aovp_prm_t prmIn,
  // Diagnosis and read back
  input wire logic [3:0] chanFault,
  input wire logic [3:0] diagRdIndex,
  input wire logic [7:0] diagRdData,
  // Results
  input wire logic [15:0] dacCode0,
  input wire logic [31:0] chanMode,
  input wire logic prmError,
  input wire logic prmRefused,
  input wire logic prmApplied
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  code_mask_a: assert property (valueIn.valid && valueIn.chan == 2'h0 |=>
    dacCode0 == ($past({valueIn.hiByte, valueIn.loByte}) & 16'hfff8)) else $error("code");
  rec0_refuse_a: assert property (prmIn.valid && !prmIn.recSet |=> prmRefused && !prmApplied)
    else $error("rec0");
  range_refuse_a: assert property (prmIn.valid && prmIn.index > 4'hd |=> prmRefused) else $error("range");
  mode_error_a: assert property (prmIn.valid && prmIn.recSet && prmIn.index == 4'h2 && prmIn.data[7:4] > 4'h2
    |=> prmError && $stable(chanMode)) else $error("moderr");
  mode_apply_a: assert property (prmIn.valid && prmIn.recSet && prmIn.index == 4'h2 && prmIn.data[7:4] == 4'h1
    |=> prmApplied && chanMode[7:0] == $past(prmIn.data)) else $error("mode");
  diag_rsvd_a: assert property (diagRdIndex == 4'h0 |-> diagRdData[7:4] == 4'h0) else $error("rsvd");
  spare_zero_a: assert property (diagRdIndex == 4'h1 |-> diagRdData == 8'h00) else $error("spare");
  diag_sticky_a: assert property (chanFault[2] ##1 diagRdIndex == 4'h0 |-> diagRdData[2]) else $error("diag");
  pulse_onehot_a: assert property ($onehot0({prmError, prmRefused, prmApplied})) else $error("onehot");
endmodule : aovp_port_properties
bind aovp_port aovp_port_properties u_chk (
  .clk(clk),
  .nrst(nrst),
  .valueIn(valueIn),
  .prmIn(prmIn),
  .chanFault(chanFault),
  .diagRdIndex(diagRdIndex),
  .diagRdData(diagRdData),
  .dacCode0(dacCode0),
  .chanMode(chanMode),
  .prmError(prmError),
  .prmRefused(prmRefused),
  .prmApplied(prmApplied)
);
`default_nettype wire

//--- sim/aovp_port_test.sv
// Testbench for the analog output value and parameter port
`timescale 1ns/10ps
`default_nettype none
module aovp_port_test;
  import aovp_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, runStart = 1'b0, prmError, prmRefused, prmApplied;
  logic [3:0] chanFault = 4'h0, diagRdIndex = 4'h0, faultSet;
  aovp_word_t valueIn;
  aovp_prm_t prmIn;
  logic [7:0] diagRdData;
  logic [15:0] dacCode0, dacCode1, dacCode2, dacCode3, w;
  logic [31:0] chanMode;
  int error_cnt = 0, cmp_count = 0, expByte [16], expCode [4];
  always #20 clk = ~clk;
  aovp_ctrl u_ctrl (
    .clk(clk),
    .valueIn(valueIn),
    .prmIn(prmIn)
  );
  aovp_port u_dut (
    .clk(clk),
    .nrst(nrst),
    .valueIn(valueIn),
    .prmIn(prmIn),
    .runStart(runStart),
    .chanFault(chanFault),
    .diagRdIndex(diagRdIndex),
    .diagRdData(diagRdData),
    .dacCode0(dacCode0),
    .dacCode1(dacCode1),
    .dacCode2(dacCode2),
    .dacCode3(dacCode3),
    .chanMode(chanMode),
    .prmError(prmError),
    .prmRefused(prmRefused),
    .prmApplied(prmApplied)
  );
  task automatic report(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask : report
  task automatic chkCode(input int c);
    logic [15:0] g;
    g = (c == 0) ? dacCode0 : (c == 1) ? dacCode1 : (c == 2) ? dacCode2 : dacCode3;
    report("dacCode", expCode[c], g);
  endtask : chkCode
  task automatic chkPulse(input logic [2:0] e);
    report("prmPulse", e, {prmError, prmRefused, prmApplied});
  endtask : chkPulse
  task automatic chkByte(input int i);
    report("areaByte", expByte[i], diagRdData);
  endtask : chkByte
  task automatic chkMode();
    report("chanMode", {expByte[7][7:0], expByte[6][7:0], expByte[5][7:0], expByte[4][7:0]}, chanMode);
  endtask : chkMode
  task automatic defaults();
    foreach (expByte[i]) expByte[i] = (i > 3 && i < 8) ? 'h19 : 0;
    foreach (expCode[i]) expCode[i] = 0;
  endtask : defaults
  task automatic conclude();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic area();
    for (int i = 0; i < 16; i++) begin
      @(posedge clk) #1 diagRdIndex = i[3:0];
      #1 chkByte(i);
    end
  endtask : area
  task automatic pp(input logic r, input logic [3:0] i, input logic [7:0] d);
    logic [2:0] e;
    e = (!r || i > 4'hd) ? 3'b010 : (i inside {[2:5]} && d[7:4] > 4'h2) ? 3'b100 : 3'b001;
    u_ctrl.prm(r, i, d);
    chkPulse(e);
    if (e[0]) expByte[i + 2] = d & (i == 0 ? 8'h40 : i == 1 ? 8'h0f : 8'hff);
  endtask : pp
  initial begin
    void'($urandom(32'h8decbf65));
    defaults();
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    area();
    for (int k = 0; k < 8; k++) begin
      w = (k != 0) ? 16'($urandom) : 16'h8007;
      u_ctrl.word(k[1:0], w);
      expCode[k % 4] = w & 16'hfff8;
      chkCode(k % 4);
    end
    for (int c = 0; c < 4; c++) begin
      chkCode(c);
    end
    pp(1'b0, 4'h0, 8'h0f);
    pp(1'b1, 4'he, 8'hff);
    pp(1'b1, 4'h2, 8'h38);
    pp(1'b1, 4'h2, 8'h12);
    pp(1'b1, 4'h3, 8'h23);
    pp(1'b1, 4'h4, 8'h00);
    pp(1'b1, 4'h0, 8'hff);
    pp(1'b1, 4'h1, 8'hff);
    runStart = 1'b1;
    @(posedge clk) #1 runStart = 1'b0;
    repeat (6) pp(1'b1, 4'($urandom % 14), 8'($urandom));
    diagRdIndex = 4'h0;
    faultSet = 4'($urandom) | 4'h4;
    chanFault = faultSet;
    @(posedge clk) #1 chanFault = 4'h0;
    expByte[0] = faultSet;
    area();
    chkMode();
    @(posedge clk) #1 nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    defaults();
    area();
    for (int c = 0; c < 4; c++) begin
      chkCode(c);
    end
    chkMode();
    conclude();
  end
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
endmodule : aovp_port_test
`default_nettype wire
